/* File: src/slc_pkg.sv */
package slc_pkg;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_STATUS        = 8'h08;

  // Sleep control fields
  localparam int         ARM_BIT            = 0;
  localparam int         MODE_LSB           = 1;
  localparam logic [7:0] SLEEP_CONTROL_RST  = 8'h00;
  localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h07;

  // Wake configuration fields
  localparam int         CFG_MAIN_RSTBY     = 0;
  localparam int         CFG_RTC_RSTBY      = 1;
  localparam int         CFG_LUT_RSTBY      = 2;
  localparam int         CFG_PERIPH_RSTBY   = 3;
  localparam int         CFG_PIN_ASYNC      = 4;
  localparam int         CFG_LUT_FILT_LSB   = 8;
  localparam int         CFG_LUT_EDGE_LSB   = 10;
  localparam logic [15:0] WAKE_CONFIG_RST   = 16'h0000;
  localparam logic [15:0] WAKE_CONFIG_MASK  = 16'h0f1f;

  // Sleep mode codes, async logic path code and detector-wait fuse code
  localparam logic [1:0] MODE_IDLE          = 2'h0;
  localparam logic [1:0] MODE_STANDBY       = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN    = 2'h2;
  localparam logic [1:0] MODE_RESERVED      = 2'h3;
  localparam logic [1:0] LUT_ASYNC_CODE     = 2'h0;
  localparam logic [1:0] BOD_WAIT_READY     = 2'h3;

  // Wake timing
  localparam int         WAKE_CYCLES        = 6;
  localparam int         OSC_START_CYCLES   = 16;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    SLC_ACTIVE = 4'b0001,
    SLC_SLEEP  = 4'b0010,
    SLC_WAKE   = 4'b0100,
    SLC_BODW   = 4'b1000
  } slc_state_t;

endpackage : slc_pkg

/* File: src/slc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; change accepted when stages two and three agree
module slc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] s1_ff;     // Metastability stage
  logic [W-1:0] s2_ff;     // Second stage
  logic [W-1:0] s3_ff;     // Third stage
  logic [W-1:0] out_ff;    // Filtered value
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_out = (agree & s3_ff) | (~agree & out_ff);

  // Shift chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule : slc_sync

`default_nettype wire

/* File: src/slc_sleep_controller.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module slc_sleep_controller #(
  parameter int OSC_START = slc_pkg::OSC_START_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // CPU side
  input  wire logic        sleep_instr,
  input  wire logic        debug_break,
  output logic             cpu_run,
  // Wake sources (same-clock logic except pin and monitor)
  input  wire logic        pin_irq,
  input  wire logic        twi_addr_irq,
  input  wire logic        vlm_irq,
  input  wire logic        lut_irq,
  input  wire logic        rtc_irq,
  input  wire logic        pit_irq,
  input  wire logic        usart_sof_irq,
  input  wire logic        usart_other_irq,
  input  wire logic        standby_periph_irq,
  input  wire logic        other_irq,
  // Brown-out detector
  input  wire logic [1:0]  brownout_config_fuse,
  input  wire logic        bod_ready,
  // Clock gates
  output logic             main_clk_en,
  output logic             rtc_clk_en,
  output logic             pit_clk_en,
  output logic             lowfreq_osc_en,
  output logic             lut_clk_en,
  output logic             periph_clk_en,
  output logic             standby_periph_clk_en
);

  // Counter width, ample for any oscillator start-up count
  localparam int CW = 16;
  // Six-cycle resume delay and oscillator start-up in counter width
  localparam logic [CW-1:0] WAKE_CNT = CW'(slc_pkg::WAKE_CYCLES);
  localparam logic [CW-1:0] OSC_CNT  = CW'(OSC_START);
  localparam logic [CW-1:0] ONE      = 16'h0001;

  // Registers
  logic [7:0]              sleep_control_ff;   // Arm bit and mode
  logic [15:0]             wake_config_ff;     // Run-in-standby and wake qualifiers
  slc_pkg::slc_state_t     state_ff;           // Controller state
  slc_pkg::slc_state_t     nxt_state;
  logic [1:0]              mode_ff;            // Mode latched at sleep entry
  logic [CW-1:0]           cnt_ff;             // Wake delay counter
  logic [CW-1:0]           nxt_cnt;
  logic [31:0]             prdata_ff;          // Read data
  logic [31:0]             nxt_prdata;
  logic                    wake_reason_ff;     // Last wake was a debug break

  // Asynchronous inputs pass the synchroniser
  // Pin sense, voltage monitor and detector ready arrive from other clocks
  logic                    pin_s;
  logic                    vlm_s;
  logic                    bod_ready_s;

  slc_sync #(.W(3)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pin_irq, vlm_irq, bod_ready}),
    .sync_out ({pin_s, vlm_s, bod_ready_s})
  );

  // Field decode
  // Control register: arm bit and requested mode
  wire       arm_bit        = sleep_control_ff[slc_pkg::ARM_BIT];
  wire [1:0] sel_mode       = sleep_control_ff[slc_pkg::MODE_LSB +: 2];
  // Wake configuration: run-in-standby, pin sensing, logic path
  wire       main_rstby     = wake_config_ff[slc_pkg::CFG_MAIN_RSTBY];
  wire       rtc_rstby      = wake_config_ff[slc_pkg::CFG_RTC_RSTBY];
  wire       lut_rstby      = wake_config_ff[slc_pkg::CFG_LUT_RSTBY];
  wire       periph_rstby   = wake_config_ff[slc_pkg::CFG_PERIPH_RSTBY];
  wire       pin_async      = wake_config_ff[slc_pkg::CFG_PIN_ASYNC];
  wire [1:0] lut_filter_select = wake_config_ff[slc_pkg::CFG_LUT_FILT_LSB +: 2];
  wire [1:0] lut_edge_detect   = wake_config_ff[slc_pkg::CFG_LUT_EDGE_LSB +: 2];

  // Mode compare helper
  function automatic logic is_mode(input logic [1:0] m, input logic [1:0] code);
    is_mode = (m == code);
  endfunction : is_mode

  // Mode in effect while asleep
  // Latched mode only counts while the controller is asleep
  wire in_sleep   = (state_ff == slc_pkg::SLC_SLEEP);
  wire idle_m     = in_sleep & is_mode(mode_ff, slc_pkg::MODE_IDLE);
  wire stby_m     = in_sleep & is_mode(mode_ff, slc_pkg::MODE_STANDBY);
  wire power_down_mode_m    = in_sleep & is_mode(mode_ff, slc_pkg::MODE_POWER_DOWN);

  // Sleep request accepted only when armed and mode valid
  // A reserved mode leaves the core running and every clock on
  wire mode_valid = ~is_mode(sel_mode, slc_pkg::MODE_RESERVED);
  wire enter      = sleep_instr & arm_bit & mode_valid;

  // Asynchronous logic path
  wire lut_async  = (lut_filter_select == slc_pkg::LUT_ASYNC_CODE) &
                    (lut_edge_detect == slc_pkg::LUT_ASYNC_CODE);

  // Wake qualification per mode
  // Address match and voltage monitor wake from every mode
  wire wake_always = twi_addr_irq | vlm_s;
  // Idle: every source wakes
  wire wake_idle   = pin_s | lut_irq | rtc_irq | pit_irq | usart_sof_irq |
                     usart_other_irq | standby_periph_irq | other_irq;
  // Standby: pins, start-of-frame, timer; RTC, standby peripherals and async logic path need run-in-standby
  wire wake_stby   = pin_s | (lut_irq & lut_async & lut_rstby) |
                     (rtc_irq & rtc_rstby) | pit_irq | usart_sof_irq |
                     (standby_periph_irq & periph_rstby);
  // Power-down: asynchronous pins and logic path, periodic timer only
  wire wake_power_down_mode  = (pin_s & pin_async) | (lut_irq & lut_async) | pit_irq;
  // Qualified request for the mode in effect
  wire wake_req    = wake_always | (idle_m & wake_idle) | (stby_m & wake_stby) |
                     (power_down_mode_m & wake_power_down_mode);
  wire wake_any    = wake_req | debug_break;

  // Wake delay length: oscillator start-up unless from idle
  wire [CW-1:0] wake_len = is_mode(mode_ff, slc_pkg::MODE_IDLE) ? WAKE_CNT :
                           WAKE_CNT + OSC_CNT;
  // Detector-ready wait only with the fuse at its wait setting
  wire bod_wait = (brownout_config_fuse == slc_pkg::BOD_WAIT_READY);

  // Next state
  always_comb
  begin
    // Defaults hold state and count
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      // Running; wait for an accepted sleep instruction
      slc_pkg::SLC_ACTIVE:
      begin
        if (enter)
        begin
          nxt_state = slc_pkg::SLC_SLEEP;
        end
      end
      // Asleep; a qualified request or break starts the wake delay
      slc_pkg::SLC_SLEEP:
      begin
        if (wake_any)
        begin
          nxt_state = slc_pkg::SLC_WAKE;
          nxt_cnt   = wake_len - ONE;
        end
      end
      // Counting the resume delay down to zero
      slc_pkg::SLC_WAKE:
      begin
        if (cnt_ff != '0)
        begin
          nxt_cnt = cnt_ff - ONE;
        end
        else if (bod_wait && !bod_ready_s)
        begin
          nxt_state = slc_pkg::SLC_BODW;
        end
        else
        begin
          nxt_state = slc_pkg::SLC_ACTIVE;
        end
      end
      // Delay over; holding until the detector is ready
      slc_pkg::SLC_BODW:
      begin
        if (bod_ready_s)
        begin
          nxt_state = slc_pkg::SLC_ACTIVE;
        end
      end
      // Illegal code falls back to running
      default:
      begin
        nxt_state = slc_pkg::SLC_ACTIVE;
      end
    endcase
  end

  // State, counter, latched mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= slc_pkg::SLC_ACTIVE;
      cnt_ff   <= '0;
      mode_ff  <= slc_pkg::MODE_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      // Mode latched only when the entry is accepted
      if (enter && state_ff == slc_pkg::SLC_ACTIVE)
      begin
        mode_ff <= sel_mode;
      end
    end
  end

  // Wake reason flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_reason_ff <= 1'b0;
    end
    // Updated at each wake; set only by a break with no request
    else if (in_sleep && wake_any)
    begin
      wake_reason_ff <= debug_break & ~wake_req;
    end
  end

  // Clock may run: off in power-down, in standby only if kept
  function automatic logic clk_run(input logic keep, input logic stby, input logic power_down_mode);
    clk_run = ~(stby & ~keep) & ~power_down_mode;
  endfunction : clk_run

  // Clock gating per mode
  // Core runs only in active mode
  assign cpu_run        = (state_ff == slc_pkg::SLC_ACTIVE);
  // Slow oscillator and periodic timer clock never stop
  assign lowfreq_osc_en = 1'b1;
  assign pit_clk_en     = 1'b1;
  // Sources with a run-in-standby setting
  assign main_clk_en    = clk_run(main_rstby, stby_m, power_down_mode_m);
  assign rtc_clk_en     = clk_run(rtc_rstby, stby_m, power_down_mode_m);
  assign lut_clk_en     = clk_run(lut_rstby, stby_m, power_down_mode_m);
  assign standby_periph_clk_en = clk_run(periph_rstby, stby_m, power_down_mode_m);
  // Remaining peripherals run in active and idle only
  assign periph_clk_en  = clk_run(1'b0, stby_m, power_down_mode_m);

  // APB decode
  // Access phase strobe and address hits
  wire acc      = psel & penable;
  wire hit_ctl  = (paddr == slc_pkg::ADDR_SLEEP_CONTROL);
  wire hit_cfg  = (paddr == slc_pkg::ADDR_WAKE_CONFIG);
  wire hit_st   = (paddr == slc_pkg::ADDR_STATUS);
  wire mapped   = hit_ctl | hit_cfg | hit_st;
  // Write strobes
  wire wr_ctl   = acc & pwrite & hit_ctl;
  wire wr_cfg   = acc & pwrite & hit_cfg;

  // No wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_control_ff <= slc_pkg::SLEEP_CONTROL_RST;
      wake_config_ff   <= slc_pkg::WAKE_CONFIG_RST;
    end
    else
    begin
      // Reserved bits are dropped and read back as zero
      if (wr_ctl)
      begin
        sleep_control_ff <= pwdata[7:0] & slc_pkg::SLEEP_CONTROL_MASK;
      end
      if (wr_cfg)
      begin
        wake_config_ff <= pwdata[15:0] & slc_pkg::WAKE_CONFIG_MASK;
      end
    end
  end

  // Read mux
  always_comb
  begin
    nxt_prdata = prdata_ff;
    // Sampled in the setup phase of a read
    if (psel && !penable && !pwrite)
    begin
      // Unmapped addresses read as zero
      nxt_prdata = '0;
      if (hit_ctl)
      begin
        nxt_prdata = {24'h0000_00, sleep_control_ff};
      end
      else if (hit_cfg)
      begin
        nxt_prdata = {16'h0000, wake_config_ff};
      end
      // Status: wake cause, latched mode, state
      else if (hit_st)
      begin
        nxt_prdata = {25'h000_0000, wake_reason_ff, mode_ff, state_ff};
      end
    end
  end

  // Read data register
  // Stands through the whole access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= '0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

endmodule : slc_sleep_controller

`default_nettype wire

/* File: tb/slc_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// Sleep entry, clock gating and wake timing seen at the ports
module slc_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sleep_instr,
  input wire logic        debug_break,
  input wire logic        cpu_run,
  input wire logic        other_irq,
  input wire logic        usart_sof_irq,
  input wire logic [1:0]  brownout_config_fuse,
  input wire logic        bod_ready,
  input wire logic        main_clk_en,
  input wire logic        pit_clk_en,
  input wire logic        lowfreq_osc_en,
  input wire logic        lut_clk_en,
  input wire logic        periph_clk_en
);
  logic [2:0] ctrl_ff;  // Shadow of control field
  logic [1:0] md_ff;    // Mode taken at entry
  wire        ctl_wr  = psel && penable && pwrite && paddr == slc_pkg::ADDR_SLEEP_CONTROL;
  wire        enter   = sleep_instr && cpu_run;
  wire        ok_fuse = brownout_config_fuse != slc_pkg::BOD_WAIT_READY;

  // Track control writes and latch mode at entry
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_ff <= 3'h0;
    else if (ctl_wr)
      ctrl_ff <= pwdata[2:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      md_ff <= 2'h0;
    else if (enter)
      md_ff <= ctrl_ff[2:1];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slow_osc_on: assert property (lowfreq_osc_en && pit_clk_en)
    else $error("slow clocks stopped");
  a_sleep_entry: assert property (enter && ctrl_ff[0] && ctrl_ff[2:1] != 2'h3 |=> !cpu_run)
    else $error("sleep not entered");
  a_reserved_stay: assert property (enter && (ctrl_ff[2:1] == 2'h3 || !ctrl_ff[0]) |=> cpu_run)
    else $error("slept without valid arm");
  a_pd_clocks_off: assert property ($fell(cpu_run) && md_ff == slc_pkg::MODE_POWER_DOWN
    |-> !(main_clk_en || lut_clk_en || periph_clk_en))
    else $error("clock left on in power down");
  a_idle_clocks_on: assert property (!cpu_run && md_ff == slc_pkg::MODE_IDLE
    |-> main_clk_en && periph_clk_en)
    else $error("clock stopped in idle");
  a_idle_wake_six: assert property ($rose(other_irq) && !cpu_run && ok_fuse
    && md_ff == slc_pkg::MODE_IDLE |-> ##1 !cpu_run [*6] ##1 cpu_run)
    else $error("idle wake time wrong");
  a_sb_wake_osc: assert property ($rose(usart_sof_irq) && !cpu_run && ok_fuse
    && md_ff == slc_pkg::MODE_STANDBY |-> ##22 !cpu_run ##1 cpu_run)
    else $error("standby wake time wrong");
  a_debug_wake: assert property ($rose(debug_break) && !cpu_run && ok_fuse |-> ##[1:30] cpu_run)
    else $error("break did not wake");
  a_bod_hold: assert property (!bod_ready [*5] ##0 (!ok_fuse && !cpu_run) |=> !cpu_run)
    else $error("woke before detector ready");
endmodule : slc_sva

bind slc_sleep_controller slc_sva slc_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleep_instr(sleep_instr),
  .debug_break(debug_break), .cpu_run(cpu_run), .other_irq(other_irq),
  .usart_sof_irq(usart_sof_irq), .brownout_config_fuse(brownout_config_fuse),
  .bod_ready(bod_ready), .main_clk_en(main_clk_en), .pit_clk_en(pit_clk_en),
  .lowfreq_osc_en(lowfreq_osc_en), .lut_clk_en(lut_clk_en), .periph_clk_en(periph_clk_en));

`default_nettype wire

/* File: tb/slc_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Core and wake sources on the far side
module slc_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cpu_run,
  input  wire logic       do_sleep,
  input  wire logic [9:0] raise,
  output var  logic       sleep_instr,
  output var  logic [9:0] irq
);
  // Sleep instruction follows do_sleep one cycle later, only while running
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sleep_instr <= 1'b0;
    else
      sleep_instr <= do_sleep && cpu_run;

  // Requests stay up until the core runs and serves them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq <= 10'h000;
    else if (cpu_run)
      irq <= raise;
    else
      irq <= irq | raise;
endmodule : slc_partner

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        do_sleep, sleep_instr, debug_break, cpu_run, bod_ready, err, got;
  logic [9:0]  raise, irq;
  logic [1:0]  fuse;
  wire  [6:0]  ce;           // main rtc pit lowfreq lut periph standby
  int          n_mismatch, checks_done;
  logic [22:0] rows [21] = '{  // Mode, wake config, source, wakes
    {2'h0, 16'h0000, 4'h7, 1'b1}, {2'h0, 16'h0000, 4'h0, 1'b1},
    {2'h0, 16'h0000, 4'h8, 1'b1}, {2'h1, 16'h0000, 4'h7, 1'b0},
    {2'h1, 16'h0001, 4'h6, 1'b1}, {2'h1, 16'h0000, 4'h8, 1'b0},
    {2'h1, 16'h0008, 4'h9, 1'b1}, {2'h1, 16'h0000, 4'h9, 1'b0},
    {2'h1, 16'h0002, 4'h4, 1'b1}, {2'h1, 16'h0000, 4'h4, 1'b0},
    {2'h1, 16'h0004, 4'h3, 1'b1}, {2'h1, 16'h0104, 4'h3, 1'b0},
    {2'h2, 16'h0000, 4'h0, 1'b0}, {2'h2, 16'h0010, 4'h0, 1'b1},
    {2'h2, 16'h0000, 4'h1, 1'b1}, {2'h2, 16'h0000, 4'h2, 1'b1},
    {2'h2, 16'h0000, 4'h6, 1'b0}, {2'h2, 16'h0000, 4'h5, 1'b1},
    {2'h2, 16'h0804, 4'h3, 1'b0}, {2'h2, 16'h0004, 4'h3, 1'b1},
    {2'h1, 16'h0000, 4'h1, 1'b1}};

  slc_sleep_controller slc_sleep_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sleep_instr(sleep_instr), .debug_break(debug_break),
    .cpu_run(cpu_run), .pin_irq(irq[0]), .twi_addr_irq(irq[1]), .vlm_irq(irq[2]),
    .lut_irq(irq[3]), .rtc_irq(irq[4]), .pit_irq(irq[5]), .usart_sof_irq(irq[6]),
    .other_irq(irq[7]), .usart_other_irq(irq[8]), .standby_periph_irq(irq[9]),
    .brownout_config_fuse(fuse), .bod_ready(bod_ready), .main_clk_en(ce[6]),
    .rtc_clk_en(ce[5]), .pit_clk_en(ce[4]), .lowfreq_osc_en(ce[3]), .lut_clk_en(ce[2]),
    .periph_clk_en(ce[1]), .standby_periph_clk_en(ce[0]));
  slc_partner slc_partner_inst (.pclk(pclk), .presetn(presetn), .cpu_run(cpu_run),
    .do_sleep(do_sleep), .raise(raise), .sleep_instr(sleep_instr), .irq(irq));

  // Clock at 4 ns
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : apb

  // Bounded wait for the core to run
  task automatic wait_run(input int n);
    got = 1'b0;
    while (n > 0 && !got)
    begin
      @(posedge pclk);
      got = (cpu_run === 1'b1);
      n--;
    end
  endtask : wait_run

  // Write control, then issue the sleep instruction
  task automatic try_sleep(input logic [31:0] v);
    apb(1'b1, slc_pkg::ADDR_SLEEP_CONTROL, v);
    @(posedge pclk);
    do_sleep <= 1'b1;
    @(posedge pclk);
    do_sleep <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : try_sleep

  // Configure, arm and sleep
  task automatic nap(input logic [1:0] m, input logic [15:0] c);
    apb(1'b1, slc_pkg::ADDR_WAKE_CONFIG, {16'h0000, c});
    try_sleep({29'h0000_0000, m, 1'b1});
    chk(cpu_run, 1'b0);
  endtask : nap

  // One-cycle pulse on a request line
  task automatic pulse(input logic [9:0] v, input logic b);
    @(posedge pclk);
    raise <= v;
    debug_break <= b;
    @(posedge pclk);
    raise <= 10'h000;
    debug_break <= 1'b0;
  endtask : pulse

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    logic [1:0]  m;
    logic [15:0] c;
    {presetn, psel, penable, pwrite, do_sleep, debug_break} = 6'h00;
    {paddr, pwdata, raise, fuse, bod_ready} = 53'h0000_0000_0000_1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, slc_pkg::ADDR_SLEEP_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, slc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    foreach (rows[i])
    begin
      m = rows[i][22:21];
      c = rows[i][20:5];
      nap(m, c);
      chk({ce[6], ce[2], ce[1], ce[0]}, m == slc_pkg::MODE_IDLE ? 4'hf :
          m == slc_pkg::MODE_STANDBY ? {c[0], c[2], 1'b0, c[3]} : 4'h0);
      chk(ce[5], m == slc_pkg::MODE_IDLE || (m == slc_pkg::MODE_STANDBY && c[1]));
      chk({ce[4], ce[3]}, 2'h3);
      pulse(10'h001 << rows[i][4:1], 1'b0);
      wait_run(40);
      chk(got, rows[i][0]);
      if (!got)
      begin
        pulse(10'h000, 1'b1);
        wait_run(40);
        chk(got, 1'b1);
      end
      apb(1'b0, slc_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, {25'h000_0000, ~rows[i][0], m, 4'h1});
    end
    apb(1'b1, slc_pkg::ADDR_SLEEP_CONTROL, 32'hffff_ffff);
    apb(1'b0, slc_pkg::ADDR_SLEEP_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    try_sleep(32'h0000_0007);
    chk(cpu_run, 1'b1);
    try_sleep(32'h0000_0004);
    chk(cpu_run, 1'b1);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    fuse <= slc_pkg::BOD_WAIT_READY;
    bod_ready <= 1'b0;
    nap(slc_pkg::MODE_IDLE, 16'h0000);
    pulse(10'h080, 1'b0);
    wait_run(30);
    chk(got, 1'b0);
    bod_ready <= 1'b1;
    wait_run(20);
    chk(got, 1'b1);
    fuse <= 2'h0;
    nap(slc_pkg::MODE_POWER_DOWN, 16'h0000);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(cpu_run, 1'b1);
    presetn <= 1'b1;
    apb(1'b0, slc_pkg::ADDR_SLEEP_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
